// file: design/rhlf_consts.svh
// Purpose: constants for the reference holdover and lock controller
// Assumes: included by its bare name
// Notes: offsets are the register port addresses
`ifndef RHLF_CONSTS_SVH
`define RHLF_CONSTS_SVH

// register offsets
`define RHLF_ADDR_LOCK_TIMER 12'h028
`define RHLF_ADDR_MAN_CTRL 12'h029
`define RHLF_ADDR_STATE 12'h082

// reset values
`define RHLF_RST_LOCK_TIMER 8'h00
`define RHLF_RST_MAN_CTRL 8'h00

// field positions in the control register
`define RHLF_CTRL_AUTO_BIT 0
`define RHLF_CTRL_FORCE_BIT 1
`define RHLF_CTRL_DAC_BIT 2
`define RHLF_CTRL_SEL_LSB 3

// writable bits of each register
`define RHLF_MASK_LOCK_TIMER 8'h1f
`define RHLF_MASK_MAN_CTRL 8'h1f

// phase error qualifying a cycle as low, in picoseconds
`define RHLF_PHASE_LIMIT_PS 16'd4000

// oscillator clock cycles per common-rate cycle
`define RHLF_RATE_DIV 4'd4

// state codes as seen in the status field
`define RHLF_CODE_INIT 3'h0
`define RHLF_CODE_PRELOAD 3'h1
`define RHLF_CODE_ACQUIRE 3'h2
`define RHLF_CODE_LOCKED 3'h3
`define RHLF_CODE_HO_ENTRY 3'h4
`define RHLF_CODE_HO_STEADY 3'h5
`define RHLF_CODE_HO_EXIT 3'h6

`endif

// file: design/rhlf_ctrl.sv
// Purpose: input loop lock detector and reference/holdover state machine
// Assumes: all inputs synchronous to sys_clk_i, the oscillator clock
// Notes: the loop logic advances on a common-rate enable from a divider
//
// What this block does
// [R1] count low-error cycles, flag lock at limit
// [R2] large phase error clears counter, restarts
// [R3] counter stops after lock until error
// [R4] limit is two to exponent; under 4 ns
// [R5] software picks exponent near loop time constant
// [R6] manual or automatic mode via control bit
// [R7] manual: select field picks ref, force holds
// [R8] status always updated; auto-only evasive action
// [R9] auto uses missing flags, error, lock, config
// [R10] reset holds machine in startup state
// [R11] preload picks best enabled valid reference
// [R12] next cycle after preload starts acquisition
// [R13] lock indication moves acquisition to locked
// [R14] lock loss, missing, clash enter holdover
// [R15] holdover tristates pump, optional dac force
// [R16] exit needs stable ref; entry/steady/exit substates
// [R17] three-bit state readable over register port
// [R18] loop logic runs at divided common rate
// [R19] slow reference raises missing flag, disqualifies
// [R20] auto switching only in preload or holdover
// [R21] each state has its own fixed status code
`timescale 1ns/1ns
`include "rhlf_consts.svh"
`default_nettype none

module rhlf_ctrl (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire rhlf_pkg::rhlf_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [15:0] phase_err_ps_i,
  input wire logic [3:0] ref_too_slow_i,
  input wire logic [3:0] ref_enable_i,
  input wire logic [7:0] ref_priority_i,
  input wire logic exit_need_low_err_i,
  output logic [3:0] signal_missing_o,
  output logic [1:0] active_ref_o,
  output logic lock_detect_o,
  output logic charge_pump_tristate_o,
  output logic dac_force_o,
  output logic [2:0] loop_state_code_o
);
  import rhlf_pkg::*;

  logic [3:0] div_cnt_r;          // common-rate divider
  logic rate_tick;                // one-cycle common-rate enable
  logic [7:0] lock_timer_r;       // lock count exponent register
  rhlf_ctrl_t ctrl_r;             // manual/holdover control register
  logic [31:0] lock_cnt_r;        // consecutive low-error count
  logic lock_r;                   // lock indication
  logic [31:0] lock_limit;        // two to the exponent
  logic low_err;                  // phase error below threshold
  logic lock_restart;             // fresh count on holdover exit
  logic [3:0] missing_r;          // signal missing flags
  logic [1:0] active_ref_r;       // selected reference
  rhlf_state_t state_r;           // current state
  rhlf_state_t state_nxt;         // next state
  logic [2:0] best;               // {found, index} from priority table
  logic best_ok;                  // a valid reference exists
  logic active_missing;           // active reference has gone
  logic clash;                    // better reference became valid
  logic pump_tri_r;               // pump tristate command
  logic dac_r;                    // dac force command
  logic [7:0] rdata_r;            // read data

  // status code for each state, fixed per state
  function automatic logic [2:0] state_code(input rhlf_state_t s);
    case (s)
      ST_INIT: state_code = `RHLF_CODE_INIT;
      ST_PRELOAD: state_code = `RHLF_CODE_PRELOAD;
      ST_ACQUIRE: state_code = `RHLF_CODE_ACQUIRE;
      ST_LOCKED: state_code = `RHLF_CODE_LOCKED;
      ST_HO_ENTRY: state_code = `RHLF_CODE_HO_ENTRY;
      ST_HO_STEADY: state_code = `RHLF_CODE_HO_STEADY;
      ST_HO_EXIT: state_code = `RHLF_CODE_HO_EXIT;
      default: state_code = `RHLF_CODE_INIT;
    endcase
  endfunction : state_code

  // true for every holdover substate
  function automatic logic is_hold(input rhlf_state_t s);
    is_hold = (s == ST_HO_ENTRY) || (s == ST_HO_STEADY) || (s == ST_HO_EXIT);
  endfunction : is_hold

  // first priority slot whose reference is enabled and present
  function automatic logic [2:0] pick_best(input logic [7:0] prio,
                                           input logic [3:0] en,
                                           input logic [3:0] miss);
    logic [1:0] idx;
    pick_best = {1'b0, prio[1:0]};
    for (int i = 3; i >= 0; i--) begin
      idx = prio[2*i +: 2];
      if (en[idx] && !miss[idx]) begin
        pick_best = {1'b1, idx};
      end
    end
  endfunction : pick_best

  // divide oscillator clock to common rate; loop logic uses tick
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      div_cnt_r <= 4'h0;
    end else if (div_cnt_r == `RHLF_RATE_DIV - 4'd1) begin
      div_cnt_r <= 4'h0; // wrap at end of common-rate period
    end else begin
      div_cnt_r <= div_cnt_r + 4'd1;
    end
  end
  assign rate_tick = (div_cnt_r == `RHLF_RATE_DIV - 4'd1); // [R18]

  // register writes
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      lock_timer_r <= `RHLF_RST_LOCK_TIMER;
      ctrl_r <= `RHLF_RST_MAN_CTRL;
    end else if (reg_req_i.wr) begin
      if (reg_req_i.addr == `RHLF_ADDR_LOCK_TIMER) begin
        lock_timer_r <= reg_req_i.wdata & `RHLF_MASK_LOCK_TIMER;
      end
      if (reg_req_i.addr == `RHLF_ADDR_MAN_CTRL) begin
        ctrl_r <= reg_req_i.wdata & `RHLF_MASK_MAN_CTRL; // [R6]
      end
    end
  end

  // register reads, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rdata_r <= 8'h00;
    end else if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        `RHLF_ADDR_LOCK_TIMER: rdata_r <= lock_timer_r;
        `RHLF_ADDR_MAN_CTRL: rdata_r <= ctrl_r;
        `RHLF_ADDR_STATE: rdata_r <= {5'h00, state_code(state_r)}; // [R17]
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  // lock detector qualifiers
  assign low_err = (phase_err_ps_i < `RHLF_PHASE_LIMIT_PS); // [R4]
  assign lock_limit = 32'h1 << lock_timer_r[4:0];           // [R4]
  assign lock_restart = rate_tick && (state_r == ST_HO_EXIT) &&
                        (state_nxt == ST_ACQUIRE);

  // lock counter and indication
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      lock_cnt_r <= 32'h0;
      lock_r <= 1'b0;
    end else if (rate_tick) begin
      if (!low_err || lock_restart) begin
        lock_cnt_r <= 32'h0; // large error restarts the count [R2]
        lock_r <= 1'b0;
      end else if (!lock_r) begin
        // counting stops once locked, until an error [R3]
        if (lock_cnt_r + 32'h1 >= lock_limit) begin
          lock_r <= 1'b1; // limit reached [R1]
        end
        lock_cnt_r <= lock_cnt_r + 32'h1;
      end
    end
  end

  // signal missing flags follow the frequency comparator [R19]
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      missing_r <= 4'h0;
    end else if (rate_tick) begin
      missing_r <= ref_too_slow_i;
    end
  end

  // candidate selection and interruption causes [R9]
  assign best = pick_best(ref_priority_i, ref_enable_i, missing_r); // [R11]
  assign best_ok = best[2];
  assign active_missing = missing_r[active_ref_r] ||
                          !ref_enable_i[active_ref_r]; // [R19]
  assign clash = best_ok && (best[1:0] != active_ref_r);

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT: state_nxt = ST_PRELOAD;                   // after release
      ST_PRELOAD: state_nxt = ST_ACQUIRE;                // [R12]
      ST_ACQUIRE: begin
        if (!ctrl_r.auto_mode && ctrl_r.force_hold) begin
          state_nxt = ST_HO_ENTRY;                       // [R7]
        end else if (ctrl_r.auto_mode && active_missing) begin
          state_nxt = ST_HO_ENTRY;                       // give up ref
        end else if (lock_r) begin
          state_nxt = ST_LOCKED;                         // [R13]
        end
      end
      ST_LOCKED: begin
        if (ctrl_r.auto_mode) begin
          if (!lock_r || active_missing || clash) begin
            state_nxt = ST_HO_ENTRY;                     // [R14]
          end
        end else if (ctrl_r.force_hold) begin
          state_nxt = ST_HO_ENTRY;                       // [R7] [R8]
        end
      end
      ST_HO_ENTRY: state_nxt = ST_HO_STEADY;             // [R16]
      ST_HO_STEADY: begin
        if (ctrl_r.auto_mode ? best_ok : !ctrl_r.force_hold) begin
          state_nxt = ST_HO_EXIT;                        // stable ref [R16]
        end
      end
      ST_HO_EXIT: begin
        if (ctrl_r.auto_mode) begin
          if (active_missing) begin
            state_nxt = ST_HO_STEADY;                    // ref failed again
          end else if (!exit_need_low_err_i || low_err) begin
            state_nxt = ST_ACQUIRE;                      // extra criterion
          end
        end else if (ctrl_r.force_hold) begin
          state_nxt = ST_HO_STEADY;
        end else begin
          state_nxt = ST_ACQUIRE;
        end
      end
      default: state_nxt = ST_INIT;
    endcase
  end

  // state register; reset holds startup state
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_r <= ST_INIT; // [R10]
    end else if (rate_tick) begin
      state_r <= state_nxt;
    end
  end

  // active reference: manual follows field, auto only switches in
  // preload or holdover steady
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      active_ref_r <= 2'h0;
    end else if (rate_tick) begin
      if (!ctrl_r.auto_mode) begin
        active_ref_r <= ctrl_r.manual_sel; // [R7]
      end else if ((state_r == ST_PRELOAD || state_r == ST_HO_STEADY) &&
                   best_ok) begin
        active_ref_r <= best[1:0]; // [R20] [R11]
      end
    end
  end

  // holdover actions, aligned with the state register
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      pump_tri_r <= 1'b0;
      dac_r <= 1'b0;
    end else if (rate_tick) begin
      pump_tri_r <= is_hold(state_nxt); // [R15]
      dac_r <= is_hold(state_nxt) && ctrl_r.dac_hold; // [R15]
    end
  end

  // outputs from flops
  assign reg_rdata_o = rdata_r;
  assign signal_missing_o = missing_r;
  assign active_ref_o = active_ref_r;
  assign lock_detect_o = lock_r;
  assign charge_pump_tristate_o = pump_tri_r;
  assign dac_force_o = dac_r;
  assign loop_state_code_o = state_code(state_r); // [R8] [R21]

  // lock issued on the tick that completes the count
  a_lock_at_limit: assert property (@(posedge sys_clk_i)  // [R1]
    disable iff (!reset_n_i)
    (rate_tick && low_err && !lock_r && !lock_restart &&
     lock_cnt_r == lock_limit - 32'h1) |=> lock_r)
    else $error("lock not issued at limit");

  // large error clears count and lock
  a_error_clears: assert property (@(posedge sys_clk_i)  // [R2]
    disable iff (!reset_n_i)
    (rate_tick && !low_err) |=> (lock_cnt_r == 32'h0 && !lock_r))
    else $error("error did not clear lock counter");

  // counter frozen while locked and quiet
  a_count_frozen: assert property (@(posedge sys_clk_i)  // [R3]
    disable iff (!reset_n_i)
    (lock_r && low_err && !lock_restart) |=> $stable(lock_cnt_r))
    else $error("lock counter moved while locked");

  // reset forces startup state
  a_reset_init: assert property (@(posedge sys_clk_i)  // [R10]
    !reset_n_i |=> (state_r == ST_INIT))
    else $error("not in startup state after reset");

  // preload lasts one common-rate cycle
  a_preload_next: assert property (@(posedge sys_clk_i)  // [R12]
    disable iff (!reset_n_i)
    (state_r == ST_PRELOAD && rate_tick) |=> (state_r == ST_ACQUIRE))
    else $error("preload not followed by acquisition");

  // lock in acquisition reaches locked within a tick
  a_acquire_lock: assert property (@(posedge sys_clk_i)  // [R13]
    disable iff (!reset_n_i)
    (state_r == ST_ACQUIRE && rate_tick && lock_r &&
     (ctrl_r.auto_mode ? !active_missing : !ctrl_r.force_hold))
    |=> (state_r == ST_LOCKED))
    else $error("lock did not move to locked");

  // auto loss of lock leaves locked state
  a_locked_leave: assert property (@(posedge sys_clk_i)  // [R14]
    disable iff (!reset_n_i)
    (state_r == ST_LOCKED && rate_tick && ctrl_r.auto_mode && !lock_r)
    |=> (state_r == ST_HO_ENTRY))
    else $error("lock loss did not enter holdover");

  // pump and dac commands follow the state entered on each tick
  a_hold_pump: assert property (@(posedge sys_clk_i)  // [R15]
    disable iff (!reset_n_i)
    rate_tick |=> (pump_tri_r == is_hold(state_r) &&
                   dac_r == (is_hold(state_r) && $past(ctrl_r.dac_hold))))
    else $error("holdover without pump tristate");

  // manual mode tracks the select field
  a_manual_ref: assert property (@(posedge sys_clk_i)  // [R7]
    disable iff (!reset_n_i)
    (rate_tick && !ctrl_r.auto_mode) |=>
    (active_ref_r == $past(ctrl_r.manual_sel)))
    else $error("manual reference not applied");

  // auto switching only from preload or holdover steady
  a_switch_window: assert property (@(posedge sys_clk_i)  // [R20]
    disable iff (!reset_n_i)
    (ctrl_r.auto_mode && $past(ctrl_r.auto_mode) &&
     $changed(active_ref_r)) |->
    ($past(state_r) == ST_PRELOAD || $past(state_r) == ST_HO_STEADY))
    else $error("reference switched outside allowed states");

  // state read returns the code
  a_state_read: assert property (@(posedge sys_clk_i)  // [R17]
    disable iff (!reset_n_i)
    (reg_req_i.rd && reg_req_i.addr == `RHLF_ADDR_STATE) |=>
    (reg_rdata_o == {5'h00, state_code($past(state_r))}))
    else $error("state read mismatch");

endmodule : rhlf_ctrl

`default_nettype wire

// file: design/rhlf_pkg.sv
// Purpose: types for the reference holdover and lock controller
// Assumes: nothing
// Notes: control struct mirrors the control register bit layout
package rhlf_pkg;

  // loop controller states
  typedef enum logic [2:0] {
    ST_INIT,
    ST_PRELOAD,
    ST_ACQUIRE,
    ST_LOCKED,
    ST_HO_ENTRY,
    ST_HO_STEADY,
    ST_HO_EXIT
  } rhlf_state_t;

  // control register layout, msb first
  typedef struct packed {
    logic [2:0] rsvd;       // reads as zero
    logic [1:0] manual_sel; // manual reference choice
    logic dac_hold;         // holdover drives tuning voltage by dac
    logic force_hold;       // manual holdover request
    logic auto_mode;        // automatic switching enable
  } rhlf_ctrl_t;

  // register port request
  typedef struct packed {
    logic wr;          // write strobe
    logic rd;          // read strobe
    logic [11:0] addr; // register address
    logic [7:0] wdata; // write data
  } rhlf_req_t;

endpackage : rhlf_pkg

// file: sim/rhlf_ref_model.sv
// Purpose: candidate references and oscillator seen by the loop logic
// Assumes: bench controls change on the rising edge
// Notes: phase error is a magnitude in ps, one value per clock
`timescale 1ns/1ns
`default_nettype none

module rhlf_ref_model (
  input wire logic clk_i,
  input wire logic big_err_i,
  input wire logic [15:0] rnd_i,
  input wire logic [3:0] slow_i,
  output logic [15:0] phase_err_ps_o,
  output logic [3:0] ref_too_slow_o
);
  // detector error, 4 ns and above when the loop is disturbed
  always @(posedge clk_i) begin
    if (big_err_i) begin
      phase_err_ps_o <= 16'd4000 + {6'h00, rnd_i[9:0]};
    end else begin
      phase_err_ps_o <= rnd_i % 16'd4000;
    end
  end
  // frequency comparator, a failed input reads as too slow
  always @(posedge clk_i) begin
    ref_too_slow_o <= slow_i;
  end
endmodule : rhlf_ref_model

`default_nettype wire

// file: sim/tb_rhlf_ctrl.sv
// Purpose: self-checking bench for the loop controller
// Assumes: loop ticks every fourth clock
// Notes: random phase error from a fixed-seed xorshift
`timescale 1ns/1ns
`include "rhlf_consts.svh"
`default_nettype none

module tb_rhlf_ctrl;
  import rhlf_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  rhlf_req_t req = '0;
  logic big_err = 1'b1; // partner disturbed
  logic edge_val = 1'b0; // boundary error values
  logic exit_low = 1'b0; // exit also needs low error
  logic [15:0] rnd = 16'h0000;
  logic [3:0] slow = 4'h0;
  logic [31:0] seed = 32'h54c15fed;
  logic [15:0] perr;
  logic [3:0] tslow;
  logic [3:0] miss;
  logic [7:0] rdata;
  logic [1:0] aref;
  logic lock;
  logic pump_ts;
  logic [3:0] ref_en = 4'hf; // enabled reference paths
  logic dac_f;
  logic [2:0] code;
  logic [7:0] v;
  logic [4:0] e;
  int mismatches = 0;
  int num_checks = 0;

  rhlf_ref_model rhlf_ref_model_i (.clk_i(sys_clk_i), .big_err_i(big_err),
    .rnd_i(rnd), .slow_i(slow), .phase_err_ps_o(perr),
    .ref_too_slow_o(tslow));
  rhlf_ctrl rhlf_ctrl_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .phase_err_ps_i(perr),
    .ref_too_slow_i(tslow), .ref_enable_i(ref_en), .ref_priority_i(8'h39),
    .exit_need_low_err_i(exit_low), .signal_missing_o(miss),
    .active_ref_o(aref), .lock_detect_o(lock),
    .charge_pump_tristate_o(pump_ts), .dac_force_o(dac_f),
    .loop_state_code_o(code));

  // clock, 100 ns period
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // next xorshift value
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // expected low-error ticks before lock
  function automatic int lock_ticks(input logic [4:0] x);
    return 1 << x;
  endfunction : lock_ticks
  // random error feed, boundary values on demand
  always @(posedge sys_clk_i) begin
    seed <= xs(seed);
    rnd <= edge_val ? (big_err ? 16'hfc00 : 16'd3999) : seed[15:0];
  end

  task automatic final_report;
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc
  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_i);
    req <= '0;
  endtask : reg_wr
  task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk_i);
    req <= '0;
    #1;
    d = rdata;
  endtask : reg_rd
  // poll the state code under a bounded count
  task automatic wait_code(input logic [2:0] c, input int n);
    int i;
    #1;
    for (i = 0; i < n && code !== c; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    chk({5'h00, code}, {5'h00, c}, "state code");
  endtask : wait_code

  // watchdog well beyond the expected run
  initial begin
    cyc(20000);
    mismatches++;
    final_report();
  end

  initial begin
    cyc(3);
    #1 chk({5'h00, code}, 8'h00, "code in reset");
    @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    reg_rd(`RHLF_ADDR_LOCK_TIMER, v);
    chk(v, `RHLF_RST_LOCK_TIMER, "timer reset");
    reg_rd(`RHLF_ADDR_MAN_CTRL, v);
    chk(v, `RHLF_RST_MAN_CTRL, "ctrl reset");
    reg_wr(`RHLF_ADDR_LOCK_TIMER, 8'hff);
    reg_rd(`RHLF_ADDR_LOCK_TIMER, v);
    chk(v, 8'h1f, "timer mask");
    reg_wr(`RHLF_ADDR_STATE, 8'hff);
    wait_code(`RHLF_CODE_ACQUIRE, 12);
    reg_rd(`RHLF_ADDR_STATE, v);
    chk(v, 8'h02, "state read");
    reg_rd(12'h100, v);
    chk(v, 8'h00, "unmapped read");
    // exponents kept small so lock shows in a few ticks
    for (int i = 0; i < 4; i++) begin
      e = (i == 3) ? 5'(2 + seed[7:0] % 3) : 5'(i);
      reg_wr(`RHLF_ADDR_LOCK_TIMER, {3'h0, e});
      edge_val <= (i == 1);
      big_err <= 1'b1;
      cyc(10);
      #1 chk({7'h00, lock}, 8'h00, "lock after error");
      big_err <= 1'b0;
      cyc(4 * lock_ticks(e) - 3);
      #1 chk({7'h00, lock}, 8'h00, "lock early");
      cyc(4);
      #1 chk({7'h00, lock}, 8'h01, "lock due");
      wait_code(`RHLF_CODE_LOCKED, 8);
      cyc(40);
      #1 chk({7'h00, lock}, 8'h01, "lock held");
    end
    edge_val <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      reg_wr(`RHLF_ADDR_MAN_CTRL, {3'h0, 2'(s), 3'h0});
      cyc(10);
      #1 chk({6'h00, aref}, 8'(s), "manual ref");
    end
    slow <= 4'hf;
    cyc(12);
    #1 chk({4'h0, miss}, 8'h0f, "missing in manual");
    chk({5'h00, code}, 8'h03, "no action in manual");
    slow <= 4'h0;
    for (int d = 0; d < 2; d++) begin
      reg_wr(`RHLF_ADDR_MAN_CTRL, {3'h0, 2'd1, 1'(d), 2'b10});
      wait_code(`RHLF_CODE_HO_ENTRY, 12);
      chk({7'h00, pump_ts}, 8'h01, "pump off");
      chk({7'h00, dac_f}, 8'(d), "dac force");
      wait_code(`RHLF_CODE_HO_STEADY, 8);
      reg_rd(`RHLF_ADDR_STATE, v);
      chk(v, 8'h05, "steady read");
      reg_wr(`RHLF_ADDR_MAN_CTRL, {3'h0, 2'd1, 1'(d), 2'b00});
      wait_code(`RHLF_CODE_HO_EXIT, 12);
      wait_code(`RHLF_CODE_ACQUIRE, 8);
      chk({7'h00, pump_ts}, 8'h00, "pump back");
      wait_code(`RHLF_CODE_LOCKED, 100);
    end
    reg_wr(`RHLF_ADDR_LOCK_TIMER, 8'h01);
    reg_wr(`RHLF_ADDR_MAN_CTRL, 8'h09);
    // lose ref 1 by missing flag, then by disable; clash brings it back
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk_i);
      slow <= (k == 0) ? 4'h2 : 4'h0;
      ref_en <= (k == 0) ? 4'hf : 4'hd;
      wait_code(`RHLF_CODE_HO_ENTRY, 12);
      wait_code(`RHLF_CODE_ACQUIRE, 24);
      chk({6'h00, aref}, 8'h02, "next priority");
      wait_code(`RHLF_CODE_LOCKED, 40);
      @(posedge sys_clk_i);
      slow <= 4'h0;
      ref_en <= 4'hf;
      wait_code(`RHLF_CODE_HO_ENTRY, 12);
      wait_code(`RHLF_CODE_ACQUIRE, 24);
      chk({6'h00, aref}, 8'h01, "clash return");
      wait_code(`RHLF_CODE_LOCKED, 40);
    end
    @(posedge sys_clk_i);
    exit_low <= 1'b1;
    big_err <= 1'b1;
    wait_code(`RHLF_CODE_HO_ENTRY, 16);
    cyc(40);
    #1 chk({5'h00, code}, 8'h06, "exit waits");
    big_err <= 1'b0;
    wait_code(`RHLF_CODE_ACQUIRE, 12);
    wait_code(`RHLF_CODE_LOCKED, 40);
    @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    cyc(4);
    #1 chk({5'h00, code}, 8'h00, "code mid reset");
    chk({1'b0, miss, lock, pump_ts, dac_f}, 8'h00, "outs mid reset");
    chk({6'h00, aref}, 8'h00, "ref mid reset");
    @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    wait_code(`RHLF_CODE_PRELOAD, 8);
    wait_code(`RHLF_CODE_ACQUIRE, 5);
    final_report();
  end
endmodule : tb_rhlf_ctrl

`default_nettype wire
